// *** bench/pin_env.sv ***
`timescale 1ns/1ns
// switches and floating lines outside both ports
module pin_env
  import gpio_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire pin_drive_t pa_drive,
  input  wire pin_drive_t pb_drive,
  input  wire logic [7:0] pb_pullup_en,
  input  wire logic [7:0] sw_en_a,     // switch actively drives the pin
  input  wire logic [7:0] sw_val_a,
  input  wire logic [7:0] sw_en_b,
  input  wire logic [7:0] sw_val_b,
  output logic [7:0]      pa_pin_in,
  output logic [7:0]      pb_pin_in
);
  logic [7:0] float_reg = 8'h55;       // undriven lines wander every cycle

  // a released line must never look stable to the design
  always @(posedge sys_clk) begin
    float_reg <= ~float_reg;
  end

  // device drive wins, then a switch, then on port b the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_pin_in[i] = !pa_drive.oe_n[i] ? pa_drive.dout[i] : sw_en_a[i] ? sw_val_a[i] : float_reg[i];
      pb_pin_in[i] = !pb_drive.oe_n[i] ? pb_drive.dout[i] : sw_en_b[i] ? sw_val_b[i] :
                     pb_pullup_en[i] ? 1'b1 : float_reg[i];
    end
  end
endmodule : pin_env

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb
  import gpio_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [9:0]  address = 10'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  pa_pin_in;
  logic [7:0]  pb_pin_in;
  logic        osc_on_pins = 1'b0;
  periph_ovr_t pb_periph = '0;
  pin_drive_t  pa_drive;
  pin_drive_t  pb_drive;
  logic [7:0]  pb_pullup_en;
  logic        wake_req;
  logic [7:0]  sw_en_a = 8'hff;
  logic [7:0]  sw_val_a = 8'hff;
  logic [7:0]  sw_en_b = 8'hff;
  logic [7:0]  sw_val_b = 8'h00;
  logic [7:0]  wake_cnt = 8'h00;       // cycles with wake_req high so far
  logic [7:0]  rdat;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;

  gpio_ports gpio_ports_i (.sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
    .pa_pin_in(pa_pin_in), .pb_pin_in(pb_pin_in), .osc_on_pins(osc_on_pins), .pb_periph(pb_periph),
    .pa_drive(pa_drive), .pb_drive(pb_drive), .pb_pullup_en(pb_pullup_en), .wake_req(wake_req));

  pin_env pin_env_i (.sys_clk(sys_clk), .pa_drive(pa_drive), .pb_drive(pb_drive), .pb_pullup_en(pb_pullup_en),
    .sw_en_a(sw_en_a), .sw_val_a(sw_val_a), .sw_en_b(sw_en_b), .sw_val_b(sw_val_b),
    .pa_pin_in(pa_pin_in), .pb_pin_in(pb_pin_in));

  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // catch one-cycle wake pulses
  always @(posedge sys_clk) begin
    if (wake_req === 1'b1) wake_cnt <= wake_cnt + 8'h01;
  end

  // hang guard; the whole run needs well under 3000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus_io(input logic wr, input logic [7:0] idx, input logic [7:0] wdat, output logic [7:0] rd);
    @(posedge sys_clk);
    address   <= {idx, 2'b00};
    writedata <= {24'h0, wdat};
    read      <= !wr;
    write     <= wr;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus_io

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    bus_io(1'b1, idx, d, unused);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    bus_io(1'b0, idx, 8'h00, got);
    check(got, exp);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  initial begin
    idle(8);
    resetn <= 1'b1;
    idle(2);
    check(pa_drive.oe_n, 8'hff);
    check(pb_pullup_en, 8'h00);
    rd_chk(IDX_PA_DIR, 8'hff);
    rd_chk(IDX_OPTION, 8'hff);
    rd_chk(IDX_CMP_CTL, 8'h07);
    rd_chk(IDX_ANA_CFG, 8'h00);
    rd_chk(8'h40, 8'h00);
    rd_chk(IDX_PA_DATA, 8'hd0);
    // every analog code, the slave-select ones included
    for (int c = 0; c < 8; c++) begin
      wr(IDX_ANA_CFG, 8'(c));
      rd_chk(IDX_PA_DATA, (c == 7) ? 8'hff : (c >= 4) ? 8'hf0 : 8'hd0);
    end
    osc_on_pins <= 1'b1;
    idle(4);
    rd_chk(IDX_PA_DATA, 8'h3f);
    sw_en_a <= 8'h00;
    wr(IDX_PA_DATA, 8'hff);
    wr(IDX_PA_DIR, 8'h00);
    rd_chk(IDX_PA_DIR, 8'h00);
    idle(2);
    check(pa_drive.oe_n, 8'hd0);
    osc_on_pins <= 1'b0;
    idle(3);
    check(pa_drive.oe_n, 8'h10);
    check(pa_drive.dout, 8'hef);
    wr(IDX_PA_DATA, 8'h00);
    idle(2);
    check(pa_drive.oe_n, 8'h00);
    wr(IDX_PA_DIR, 8'hff);
    // pull-ups on, low nibble of port b driven
    wr(IDX_OPTION, 8'h7f);
    idle(2);
    check(pb_pullup_en, 8'hff);
    wr(IDX_PB_DIR, 8'hf0);
    idle(2);
    check(pb_pullup_en, 8'hf0);
    pb_periph <= '{en: 8'h80, dir: 8'h00, dout: 8'h80};
    idle(3);
    check(pb_pullup_en, 8'h70);
    check(pb_drive.oe_n, 8'h70);
    check(pb_drive.dout, 8'h80);
    pb_periph <= '0;
    sw_val_b <= 8'h30;
    wr(IDX_PB_DATA, 8'ha5);
    idle(4);
    rd_chk(IDX_PB_DATA, 8'h35);
    wr(IDX_INT_CTL, 8'h00);
    rdat = wake_cnt;
    sw_val_b <= 8'h10;
    idle(6);
    rd_chk(IDX_INT_CTL, 8'h01);
    check(8'(wake_cnt != rdat), 8'h01);
    wr(IDX_INT_CTL, 8'h00);
    rd_chk(IDX_INT_CTL, 8'h01);
    rd_chk(IDX_PB_DATA, 8'h15);
    wr(IDX_INT_CTL, 8'h00);
    idle(3);
    rd_chk(IDX_INT_CTL, 8'h00);
    // b7 as output: its own change must not count
    wr(IDX_PB_DIR, 8'h70);
    idle(4);
    rd_chk(IDX_PB_DATA, 8'h95);
    wr(IDX_INT_CTL, 8'h00);
    wr(IDX_PB_DATA, 8'h25);
    idle(6);
    rd_chk(IDX_INT_CTL, 8'h00);
    // b0 edge flag for each edge selection
    wr(IDX_PB_DIR, 8'hff);
    idle(4);
    rd_chk(IDX_PB_DATA, 8'h10);
    for (int e = 0; e < 2; e++) begin
      wr(IDX_OPTION, e ? 8'hff : 8'hbf);
      sw_val_b[0] <= e[0];
      idle(5);
      wr(IDX_INT_CTL, 8'h00);
      sw_val_b[0] <= !e[0];
      idle(5);
      rd_chk(IDX_INT_CTL, 8'h00);
      sw_val_b[0] <= e[0];
      idle(5);
      rd_chk(IDX_INT_CTL, 8'h02);
    end
    test_done();
  end
endmodule : tb

// *** verilog/gpio_pkg.sv ***
package gpio_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_PA_DATA  = 8'h05;
  localparam logic [7:0] IDX_PB_DATA  = 8'h06;
  localparam logic [7:0] IDX_INT_CTL  = 8'h0b;
  localparam logic [7:0] IDX_OPTION   = 8'h81;
  localparam logic [7:0] IDX_PA_DIR   = 8'h85;
  localparam logic [7:0] IDX_PB_DIR   = 8'h86;
  localparam logic [7:0] IDX_CMP_CTL  = 8'h9c;
  localparam logic [7:0] IDX_CMP_VREF = 8'h9d;
  localparam logic [7:0] IDX_ANA_CFG  = 8'h9f;
  // values after reset
  localparam logic [7:0] RST_LATCH    = 8'h00;
  localparam logic [7:0] RST_DIR      = 8'hff;
  localparam logic [7:0] RST_OPTION   = 8'hff;
  localparam logic [7:0] RST_CMP_CTL  = 8'h07;
  localparam logic [7:0] RST_CMP_VREF = 8'h00;
  localparam logic [7:0] RST_ANA_CFG  = 8'h00;
  localparam logic [1:0] RST_FLAGS    = 2'h0;
  // field positions and masks
  localparam int         PULLUP_DIS_N_BIT = 7;
  localparam int         EDGE_SEL_BIT     = 6;
  localparam int         CHG_FLAG_BIT     = 0;
  localparam int         EXT_FLAG_BIT     = 1;
  localparam int         OPEN_DRAIN_BIT   = 4;
  localparam logic [7:0] OSC_PIN_MASK     = 8'hc0;
  localparam logic [7:0] CHG_PIN_MASK     = 8'hf0;
  localparam logic [7:0] CMP_VREF_MASK    = 8'hef;
  localparam logic [2:0] CODE_ALL_DIGITAL = 3'h7;
  localparam int         IDX_LSB          = 2;

  // pin driver pair; oe_n low while the pin is driven
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } pin_drive_t;

  // peripheral takeover of port b pins
  typedef struct packed {
    logic [7:0] en;    // peripheral owns the pin
    logic [7:0] dir;   // forced direction, 1 = input
    logic [7:0] dout;  // peripheral output value
  } periph_ovr_t;
endpackage : gpio_pkg

// *** verilog/gpio_ports.sv ***
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
// Contract
// - direction one floats pin, zero drives latch
// - data reads pins, writes go to latch
// - oscillator pins read zero with direction, latch
// - reset: a0-a3,a5 analog reading zero, a4 digital
// - a4 open drain output, never drives high
// - analog code selects analog port a pins
// - direction still drives analog pins; software keeps ones
// - one active-low bit enables all pull-ups
// - output pins lose their pull-up
// - pull-ups off after power-on reset
// - only input pins b4-b7 are compared
// - mismatch against last port b access sets change flag
// - change event wakes device from sleep
// - port b read or write refreshes compare value
// - mismatch keeps setting flag; read then clear
// - b0 external interrupt with selectable edge
// - enabled peripheral overrides b direction
// - enabled peripheral takes pin from gpio
module gpio_ports
  import gpio_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [9:0]  address,      // byte address
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [7:0]  pa_pin_in,    // port a pin levels
  input  wire logic [7:0]  pb_pin_in,    // port b pin levels
  input  wire logic        osc_on_pins,  // a6/a7 serve the oscillator
  input  wire periph_ovr_t pb_periph,    // peripheral takeover
  output pin_drive_t       pa_drive,
  output pin_drive_t       pb_drive,
  output logic [7:0]       pb_pullup_en, // weak pull-up per pin
  output logic             wake_req      // wake from sleep
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // timing overview for the bus side:
  // request seen with waitrequest high at one edge,
  // waitrequest drops for exactly one cycle after it,
  // and the write or the refresh lands on the edge
  // at which the master samples waitrequest low.
  // read data are captured one edge early, so a read
  // shows the register as it stood before that edge.
  // pin side: every pin level passes two flops first,
  // so a switch change reaches the flags three edges
  // after it appears on the pin.
  // trade-off: the extra latency keeps metastable
  // levels out of the compare and the edge detector.

  // software state
  logic [7:0] pa_lat_reg;     // port a output latch
  logic [7:0] pb_lat_reg;     // port b output latch
  logic [7:0] pa_dir_reg;     // port a direction
  logic [7:0] pb_dir_reg;     // port b direction
  logic [7:0] opt_reg;        // option control
  logic [7:0] cmp_reg;        // comparator control, stored only
  logic [7:0] vref_reg;       // comparator reference, stored only
  logic [7:0] ana_reg;        // analog pin configuration
  logic [1:0] flags_reg;      // change and external flags
  // pin side
  logic [7:0] pa_s1_reg;      // synchroniser first stages
  logic [7:0] pb_s1_reg;
  logic [7:0] pa_s2_reg;      // synchronised levels
  logic [7:0] pb_s2_reg;
  logic       b0_prev_reg;    // b0 one cycle older
  logic [3:0] chg_old_reg;    // b4-b7 value at last access
  logic       osc_reg;        // registered oscillator strap
  // bus and output state
  logic        wait_reg;
  logic [31:0] rdata_reg;
  pin_drive_t  pa_drive_reg;
  pin_drive_t  pb_drive_reg;
  logic [7:0]  pullup_reg;
  logic        wake_reg;
  // combinational
  logic [7:0] idx;            // register index of the access
  logic       req;
  logic       accept;         // the edge that completes the access
  logic       wr_ok;          // write of the low byte is accepted
  logic [7:0] ana_a;          // port a pins in analog role
  logic [7:0] osc_m;          // oscillator-owned pins
  logic [7:0] pb_dir_eff;     // direction after peripheral override
  logic [7:0] pb_out_eff;     // output value after override
  logic       mismatch;
  logic       ext_edge;
  logic [7:0] rd_mux;

  assign idx    = address[IDX_LSB +: 8];
  assign req    = read | write;
  assign accept = req & ~wait_reg;
  assign wr_ok  = accept & write & byteenable[0];
  assign osc_m  = osc_reg ? OSC_PIN_MASK : 8'h00;

  // analog role per pin: a5 free for slave select on codes 1xx
  always_comb begin
    ana_a = 8'h00;
    ana_a[5] = ~ana_reg[2];
    ana_a[3:0] = (ana_reg[2:0] == CODE_ALL_DIGITAL) ? 4'h0 : 4'hf;
  end

  // an enabled peripheral owns the pin and its direction
  always_comb begin
    pb_dir_eff = (pb_periph.en & pb_periph.dir) | (~pb_periph.en & pb_dir_reg);
    pb_out_eff = (pb_periph.en & pb_periph.dout) | (~pb_periph.en & pb_lat_reg);
  end

  // two-stage synchronisers; first stage feeds only the second
  // reset value zero: a pin held high after reset looks like
  // a rising edge on b0 and a change on b4-b7 a few cycles
  // later; software reads port b once after reset to settle.
  // the oscillator strap is registered here as well; the read
  // masks follow it at once, the pin drivers one edge later.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pa_s1_reg <= 8'h00;
      pb_s1_reg <= 8'h00;
      pa_s2_reg <= 8'h00;
      pb_s2_reg <= 8'h00;
      b0_prev_reg <= 1'b0;
      osc_reg <= 1'b0;
    end else begin
      pa_s1_reg <= pa_pin_in;
      pb_s1_reg <= pb_pin_in;
      pa_s2_reg <= pa_s1_reg;
      pb_s2_reg <= pb_s1_reg;
      b0_prev_reg <= pb_s2_reg[0];
      osc_reg <= osc_on_pins;
    end
  end

  // change compare on input pins b4-b7 only
  assign mismatch = |(((pb_s2_reg[7:4] ^ chg_old_reg) & pb_dir_eff[7:4]));
  // b0 edge select: one picks the rising edge
  assign ext_edge = opt_reg[EDGE_SEL_BIT] ? (pb_s2_reg[0] & ~b0_prev_reg)
                                          : (~pb_s2_reg[0] & b0_prev_reg);

  // compare value refreshed by any completed port b access
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chg_old_reg <= 4'h0;
    end else if (accept && idx == IDX_PB_DATA) begin
      chg_old_reg <= pb_s2_reg[7:4];
    end
  end

  // flags: a set in the clearing cycle wins over the clear
  // a write of zero clears a flag, a write of one keeps it,
  // so software can clear one flag without losing the other.
  // limitation: while a mismatch persists the change flag
  // cannot be cleared; port b must be read or written first.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= RST_FLAGS;
    end else if (wr_ok && idx == IDX_INT_CTL) begin
      flags_reg <= (flags_reg & writedata[1:0]) | {ext_edge, mismatch};
    end else begin
      flags_reg <= flags_reg | {ext_edge, mismatch};
    end
  end

  // wake request follows the live events, not the sticky flags
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= mismatch | ext_edge;
    end
  end

  // register writes land on the edge that completes the access
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pa_lat_reg <= RST_LATCH;
      pb_lat_reg <= RST_LATCH;
      pa_dir_reg <= RST_DIR;
      pb_dir_reg <= RST_DIR;
      opt_reg <= RST_OPTION;
      cmp_reg <= RST_CMP_CTL;
      vref_reg <= RST_CMP_VREF;
      ana_reg <= RST_ANA_CFG;
    end else if (wr_ok) begin
      unique case (idx)
        IDX_PA_DATA:  pa_lat_reg <= writedata[7:0];
        IDX_PB_DATA:  pb_lat_reg <= writedata[7:0];
        IDX_PA_DIR:   pa_dir_reg <= writedata[7:0];
        IDX_PB_DIR:   pb_dir_reg <= writedata[7:0];
        IDX_OPTION:   opt_reg <= writedata[7:0];
        IDX_CMP_CTL:  cmp_reg <= writedata[7:0];
        IDX_CMP_VREF: vref_reg <= writedata[7:0] & CMP_VREF_MASK;
        IDX_ANA_CFG:  ana_reg <= writedata[7:0];
        default: ; // unmapped or flag register: nothing stored here
      endcase
    end
  end

  // read mux; port data reads show pins, not latches
  always_comb begin
    unique case (idx)
      IDX_PA_DATA:  rd_mux = pa_s2_reg & ~ana_a & ~osc_m;
      IDX_PB_DATA:  rd_mux = pb_s2_reg;
      IDX_INT_CTL:  rd_mux = {6'h00, flags_reg};
      IDX_OPTION:   rd_mux = opt_reg;
      IDX_PA_DIR:   rd_mux = pa_dir_reg & ~osc_m;
      IDX_PB_DIR:   rd_mux = pb_dir_reg;
      IDX_CMP_CTL:  rd_mux = cmp_reg;
      IDX_CMP_VREF: rd_mux = vref_reg;
      IDX_ANA_CFG:  rd_mux = ana_reg;
      default:      rd_mux = 8'h00; // unmapped reads as zero
    endcase
  end

  // one wait cycle per access; data loaded as waitrequest drops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (req && wait_reg) begin
      wait_reg <= 1'b0;
      rdata_reg <= {24'h00_0000, rd_mux};
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // pin drivers; analog pins still follow direction bits
  // a4 is open drain: a one in its latch releases the pin
  // rather than driving it, so oe_n carries the data there.
  // oscillator pins are never driven while the strap is set.
  // port b direction and value come after the peripheral
  // override, so a takeover needs no change of registers.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pa_drive_reg <= '{dout: 8'h00, oe_n: 8'hff};
      pb_drive_reg <= '{dout: 8'h00, oe_n: 8'hff};
    end else begin
      pa_drive_reg.dout <= pa_lat_reg & ~(8'h01 << OPEN_DRAIN_BIT);
      pa_drive_reg.oe_n <= (pa_dir_reg | osc_m) |
                           (pa_lat_reg & (8'h01 << OPEN_DRAIN_BIT));
      pb_drive_reg.dout <= pb_out_eff;
      pb_drive_reg.oe_n <= pb_dir_eff;
    end
  end

  // global active-low enable, masked off on output pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pullup_reg <= 8'h00;
    end else begin
      pullup_reg <= {8{~opt_reg[PULLUP_DIS_N_BIT]}} & pb_dir_eff;
    end
  end

  assign readdata     = rdata_reg;
  assign waitrequest  = wait_reg;
  assign pa_drive     = pa_drive_reg;
  assign pb_drive     = pb_drive_reg;
  assign pb_pullup_en = pullup_reg;
  assign wake_req     = wake_reg;

  // completed read of a given register
  sequence s_read_done(logic [7:0] r);
    read && !waitrequest && idx == r;
  endsequence
  // completed access of any kind to a given register
  sequence s_access_done(logic [7:0] r);
    req && !waitrequest && idx == r;
  endsequence

  a_dir_input_float: assert property (pa_dir_reg[0] |=> pa_drive.oe_n[0])
    else $error("input direction did not float pin");
  a_dir_output_drive: assert property (!pb_dir_eff[1] |=>
      (!pb_drive.oe_n[1] && pb_drive.dout[1] == $past(pb_out_eff[1])))
    else $error("output pin not driving latch");
  a_opendrain_no_high: assert property (pa_drive.oe_n[4] || !pa_drive.dout[4])
    else $error("open-drain pin driven high");
  a_osc_read_zero: assert property (s_read_done(IDX_PA_DIR) and
      $past(osc_reg) |-> readdata[7:6] == 2'h0)
    else $error("oscillator pins read non-zero");
  a_analog_read_zero: assert property (s_read_done(IDX_PA_DATA) and
      $past(ana_a[0]) |-> !readdata[0])
    else $error("analog pin read non-zero");
  a_pullup_output_off: assert property ((pb_pullup_en & ~$past(pb_dir_eff)) == 8'h00)
    else $error("pull-up on an output pin");
  a_pullup_global: assert property ($past(opt_reg[7]) |-> pb_pullup_en == 8'h00)
    else $error("pull-ups on while disabled");
  a_change_excluded: assert property (pb_dir_eff[7:4] == 4'h0 |-> !mismatch)
    else $error("output pin caused mismatch");
  a_change_flag_set: assert property (mismatch |=> flags_reg[CHG_FLAG_BIT] [*1])
    else $error("mismatch did not set flag");
  a_compare_refresh: assert property (s_access_done(IDX_PB_DATA) |=>
      chg_old_reg == $past(pb_s2_reg[7:4]))
    else $error("compare value not refreshed");
  a_ext_edge_flag: assert property (ext_edge |=> flags_reg[EXT_FLAG_BIT] && wake_req)
    else $error("external edge lost");
  a_wake_on_change: assert property (mismatch |=> wake_req)
    else $error("change did not request wake");
  // both sampled edges must lie outside reset, else the stages
  // still hold their reset zeros
  a_sync_two_stage: assert property ($past(resetn) && $past(resetn, 2) |->
      pb_s2_reg == $past(pb_pin_in, 2))
    else $error("synchroniser depth wrong");
  a_bus_answer: assert property ($rose(req) |-> ##[1:2] !waitrequest)
    else $error("bus answer late");

  // waitrequest low stands for one cycle only, so a held
  // request cannot complete twice in a row
  a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");

  // a completed port b write lands in the latch, not elsewhere
  a_pb_write_latch: assert property (wr_ok && idx == IDX_PB_DATA |=>
      pb_lat_reg == $past(writedata[7:0]))
    else $error("port b write missed latch");

  // a clear written while the mismatch persists must not win
  a_flag_hold_mismatch: assert property (mismatch && wr_ok && idx == IDX_INT_CTL |=>
      flags_reg[CHG_FLAG_BIT])
    else $error("change flag lost while mismatch held");

  // a peripheral that owns b7 sets its direction on the pin
  a_periph_takes_pin: assert property (pb_periph.en[7] |=>
      pb_drive.oe_n[7] == $past(pb_periph.dir[7]))
    else $error("peripheral did not take pin");

  // oscillator pins are released while the strap holds them
  a_osc_pins_float: assert property (osc_reg |=> pa_drive.oe_n[7:6] == 2'h3)
    else $error("oscillator pin driven");
endmodule : gpio_ports
